//--- src/abseq_core.sv
// Answerback sequencer top: row store stepping, code merge and line control.
//
// Overview of operation
// - Start on call character, identification key or external trip input.
// - Store holds start row plus rows 1 to 20, visited cyclically.
// - Each row has eight code levels, a stop flag and a suppress flag.
// - Programmed level drives its code bit marking; unprogrammed stays spacing.
// - Level numbers map directly onto character bit positions.
// - Consecutive characters come from consecutive rows, one per distributor cycle.
// - Pointer advances one row at cycle end; first cycle senses current row.
// - Keep distributor cycling until next stop position, then go idle.
// - Sequencer code is ORed with keyboard code at the distributor input.
// - While idle the sequencer adds only spacing, so the code output carries the keyboard code alone.
// - Active row suppress flag cuts transmission, holding the line marking.
// - Suppress flags on later rows are honoured the same way.
// - Suppression path disabled when the sequence ends and while idle.
// - Stop positions are configurable per row, setting message length.
// - Call detection is inhibited for locally originated characters.
// - Trip starts once, then is latched until the input drops and returns.
// - Remote trigger fires when received character equals the call character.
// - Once triggered, stay active for the whole first distributor cycle.
// - Locally initiated characters are blocked; received remote characters pass.
module abseq_core
  import abseq_pkg::*;
#(
  parameter logic [7:0] CALL_CHAR = ABSEQ_CALL_CHAR_DEF,
  parameter int ROWS = ABSEQ_ROWS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Decoded received characters from the function logic
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_local,
  // Local and external triggers
  input wire logic local_ident_key,
  input wire logic trip_in,
  // Static row store configuration
  input wire logic [ROWS-1:0][ABSEQ_LEVELS-1:0] row_code,
  input wire logic [ROWS-1:0] row_stop,
  input wire logic [ROWS-1:0] row_supp,
  // Distributor side
  input wire logic [ABSEQ_LEVELS-1:0] kbd_code,
  input wire logic dist_cycle_end,
  output logic dist_run,
  output logic [ABSEQ_LEVELS-1:0] dist_code,
  output logic line_mark,
  // Status
  output logic seq_active,
  output logic [ABSEQ_PTR_W-1:0] cur_row,
  output logic [1:0] last_src,
  output logic seq_done,
  output logic trig_ignored,
  output logic first_row_err,
  output logic no_stop_err,
  output logic [7:0] chars_sent,
  output logic [7:0] seq_count
);

  typedef enum logic [1:0] {
    ABSEQ_IDLE,
    ABSEQ_FIRST,
    ABSEQ_RUN
  } abseq_state_e;

  abseq_trig_if trig ();

  abseq_state_e state_q;
  abseq_state_e state_d;
  abseq_ptr_t ptr_q;
  abseq_ptr_t ptr_nx;
  logic active;
  logic stop_next;
  logic take_trig;
  logic dist_run_q;
  abseq_code_t dist_code_q;
  logic line_mark_q;
  logic active_q;
  abseq_ptr_t cur_row_q;
  logic [1:0] last_src_q;
  logic seq_done_q;
  logic trig_ignored_q;
  logic first_row_err_q;
  logic no_stop_err_q;
  logic [7:0] chars_sent_q;
  logic [7:0] seq_count_q;

  // Cyclic successor of a row.
  function automatic abseq_ptr_t next_row(input abseq_ptr_t p);
    abseq_ptr_t r;
    r = ABSEQ_START_ROW;
    if (p != ABSEQ_LAST_ROW)
    begin
      r = p + 5'h01;
    end
    return r;
  endfunction : next_row

  // Sequencer contribution for one row: level n is bit n-1, removed means marking.
  function automatic abseq_code_t row_bits(input abseq_code_t levels, input logic on);
    abseq_code_t r;
    r = ABSEQ_SPACING_CODE;
    if (on)
    begin
      r = levels;
    end
    return r;
  endfunction : row_bits

  abseq_trigger #(
    .CALL_CHAR(CALL_CHAR)
  ) u_trigger (
    .clk(clk),
    .rst(rst),
    .rx_valid(rx_valid),
    .rx_char(rx_char),
    .rx_local(rx_local),
    .local_ident_key(local_ident_key),
    .trip_in(trip_in),
    .trig(trig.detector)
  );

  assign active = (state_q != ABSEQ_IDLE);
  assign trig.busy = active;
  assign take_trig = trig.start && !active;
  assign ptr_nx = next_row(ptr_q);
  // The stop cam indentation is sensed on the row the drum is about to present.
  assign stop_next = row_stop[ptr_nx];

  // Sequence state. A trigger only opens the first cycle; only the cycle end can close it.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ABSEQ_IDLE:
      begin
        if (take_trig)
        begin
          state_d = ABSEQ_FIRST;
        end
      end
      ABSEQ_FIRST:
      begin
        if (dist_cycle_end)
        begin
          state_d = stop_next ? ABSEQ_IDLE : ABSEQ_RUN;
        end
      end
      ABSEQ_RUN:
      begin
        if (dist_cycle_end && stop_next)
        begin
          state_d = ABSEQ_IDLE;
        end
      end
      default:
      begin
        state_d = ABSEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ABSEQ_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Row pointer keeps its position while idle, so each message starts where the last stopped.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ptr_q <= ABSEQ_START_ROW;
    end
    else if (active && dist_cycle_end)
    begin
      ptr_q <= ptr_nx;
    end
  end

  // Distributor run request follows the sequence state.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dist_run_q <= 1'b0;
    end
    else
    begin
      dist_run_q <= (state_d != ABSEQ_IDLE);
    end
  end

  // Contact merge: idle leaves the keyboard alone, active adds the sensed row.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dist_code_q <= ABSEQ_SPACING_CODE;
    end
    else
    begin
      dist_code_q <= kbd_code | row_bits(row_code[ptr_q], active);
    end
  end

  // Suppression is gated by activity, so row flags have no effect while idle.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      line_mark_q <= 1'b0;
    end
    else
    begin
      line_mark_q <= active && row_supp[ptr_q];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      active_q <= 1'b0;
      cur_row_q <= ABSEQ_START_ROW;
    end
    else
    begin
      active_q <= active;
      cur_row_q <= ptr_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      last_src_q <= ABSEQ_SRC_NONE;
    end
    else if (take_trig)
    begin
      last_src_q <= trig.src;
    end
  end

  // One-cycle pulses: sequence end and a trigger refused because a sequence is running.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      seq_done_q <= 1'b0;
      trig_ignored_q <= 1'b0;
    end
    else
    begin
      seq_done_q <= active && (state_d == ABSEQ_IDLE);
      trig_ignored_q <= trig.start && active;
    end
  end

  // A first row without suppression would let a spacing or stray character reach the line.
  // The flag reports that misprogramming but does not stop the sequence.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      first_row_err_q <= 1'b0;
    end
    else if (take_trig)
    begin
      first_row_err_q <= !row_supp[ptr_q];
    end
  end

  // With no stop position anywhere the drum would run forever; this is reported only.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      no_stop_err_q <= 1'b0;
    end
    else
    begin
      no_stop_err_q <= (row_stop == '0);
    end
  end

  // Characters actually put on the line in the current or last sequence.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      chars_sent_q <= ABSEQ_COUNT_RST;
    end
    else if (take_trig)
    begin
      chars_sent_q <= ABSEQ_COUNT_RST;
    end
    else if (active && dist_cycle_end && !row_supp[ptr_q])
    begin
      chars_sent_q <= chars_sent_q + 8'h01;
    end
  end

  // Sequences started since reset; wraps silently.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      seq_count_q <= ABSEQ_COUNT_RST;
    end
    else if (take_trig)
    begin
      seq_count_q <= seq_count_q + 8'h01;
    end
  end

  assign dist_run = dist_run_q;
  assign dist_code = dist_code_q;
  assign line_mark = line_mark_q;
  assign seq_active = active_q;
  assign cur_row = cur_row_q;
  assign last_src = last_src_q;
  assign seq_done = seq_done_q;
  assign trig_ignored = trig_ignored_q;
  assign first_row_err = first_row_err_q;
  assign no_stop_err = no_stop_err_q;
  assign chars_sent = chars_sent_q;
  assign seq_count = seq_count_q;

endmodule : abseq_core

//--- include/abseq_pkg.sv
// Shared constants and types of the answerback sequencer.
package abseq_pkg;

  // Store geometry: one start row followed by rows 1 through 20.
  localparam int ABSEQ_ROWS = 21;
  localparam int ABSEQ_LEVELS = 8;
  localparam int ABSEQ_PTR_W = 5;

  // Position of the start row (the row pointer reset value) and of the last row.
  localparam logic [ABSEQ_PTR_W-1:0] ABSEQ_START_ROW = 5'h00;
  localparam logic [ABSEQ_PTR_W-1:0] ABSEQ_LAST_ROW = 5'h14;

  // Default call character.
  localparam logic [7:0] ABSEQ_CALL_CHAR_DEF = 8'h85;

  // Reset values of the code and counter outputs.
  localparam logic [7:0] ABSEQ_SPACING_CODE = 8'h00;
  localparam logic [7:0] ABSEQ_COUNT_RST = 8'h00;

  // Encoding of the trigger source.
  localparam logic [1:0] ABSEQ_SRC_NONE = 2'h0;
  localparam logic [1:0] ABSEQ_SRC_CALL = 2'h1;
  localparam logic [1:0] ABSEQ_SRC_KEY = 2'h2;
  localparam logic [1:0] ABSEQ_SRC_TRIP = 2'h3;

  typedef logic [ABSEQ_LEVELS-1:0] abseq_code_t;
  typedef logic [ABSEQ_PTR_W-1:0] abseq_ptr_t;

endpackage : abseq_pkg

//--- include/abseq_trig_if.sv
// Trigger carrier between the trigger detector and the sequencer core.
interface abseq_trig_if;
  logic start;
  logic [1:0] src;
  logic busy;

  modport detector (output start, output src, input busy);
  modport core (input start, input src, output busy);
endinterface : abseq_trig_if

//--- src/abseq_trigger.sv
// Trigger detector: call character, identification key and trip input.
module abseq_trigger
  import abseq_pkg::*;
#(
  parameter logic [7:0] CALL_CHAR = ABSEQ_CALL_CHAR_DEF
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Decoded received characters
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_local,
  // Local and external triggers
  input wire logic local_ident_key,
  input wire logic trip_in,
  // Towards the core
  abseq_trig_if.detector trig
);

  logic key_q;
  logic trip_used_q;
  logic call_hit;
  logic key_hit;
  logic trip_hit;

  // Characters the station originates itself never reach the comparator.
  assign call_hit = rx_valid && !rx_local && (rx_char == CALL_CHAR);
  assign key_hit = local_ident_key && !key_q;
  // A trip that arrives while busy still counts as consumed, as the latch is mechanical.
  assign trip_hit = trip_in && !trip_used_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      key_q <= 1'b0;
    end
    else
    begin
      key_q <= local_ident_key;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      trip_used_q <= 1'b0;
    end
    else if (!trip_in)
    begin
      trip_used_q <= 1'b0;
    end
    else if (trip_hit)
    begin
      trip_used_q <= 1'b1;
    end
  end

  // Any of the three sources starts the sequence; call has priority for the source tag.
  assign trig.start = call_hit || key_hit || trip_hit;
  assign trig.src = call_hit ? ABSEQ_SRC_CALL :
                    key_hit ? ABSEQ_SRC_KEY :
                    trip_hit ? ABSEQ_SRC_TRIP : ABSEQ_SRC_NONE;

endmodule : abseq_trigger

//--- verif/abseq_monitor.sv
// Port checker for the answerback sequencer.
module abseq_monitor
  import abseq_pkg::*;
#(
  parameter logic [7:0] CALL_CHAR = ABSEQ_CALL_CHAR_DEF,
  parameter int ROWS = ABSEQ_ROWS
)
(
  // Clock, reset and triggers
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_local,
  input wire logic local_ident_key,
  input wire logic trip_in,
  // Store and distributor
  input wire logic [ROWS-1:0][ABSEQ_LEVELS-1:0] row_code,
  input wire logic [ROWS-1:0] row_stop,
  input wire logic [ROWS-1:0] row_supp,
  input wire logic [ABSEQ_LEVELS-1:0] kbd_code,
  input wire logic dist_cycle_end,
  input wire logic dist_run,
  input wire logic [ABSEQ_LEVELS-1:0] dist_code,
  input wire logic line_mark,
  // Status
  input wire logic seq_active,
  input wire logic [ABSEQ_PTR_W-1:0] cur_row,
  input wire logic [1:0] last_src,
  input wire logic seq_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic trip_used_q;
  logic [ABSEQ_PTR_W-1:0] nxt_row;
  logic call_hit;
  logic idle;
  assign nxt_row = (cur_row == ABSEQ_LAST_ROW) ? ABSEQ_START_ROW : cur_row + 5'h01;
  assign call_hit = rx_valid && !rx_local && rx_char == CALL_CHAR;
  assign idle = !seq_active && !dist_run;
  // A trip that was high while busy stays spent until the input drops.
  always_ff @(posedge clk)
  begin
    if (rst || !trip_in)
      trip_used_q <= 1'b0;
    else if (seq_active)
      trip_used_q <= 1'b1;
  end
  sequence s_run;
    seq_active && dist_run;
  endsequence
  sequence s_end;
    s_run ##0 dist_cycle_end && !$past(dist_cycle_end);
  endsequence
  a_idle_code_kbd: assert property (idle && $past(idle) && !$past(rst) |-> dist_code == $past(kbd_code))
    else $error("idle code");
  a_idle_no_mark: assert property (idle && $past(idle) |-> !line_mark)
    else $error("idle mark");
  a_code_row_merge: assert property (s_run |-> dist_code == ($past(kbd_code) | row_code[cur_row]))
    else $error("row code");
  a_supp_line_mark: assert property (s_run |-> line_mark == row_supp[cur_row])
    else $error("suppress");
  // The run request rises one cycle ahead of the registered activity flag.
  a_key_start: assert property (idle && $rose(local_ident_key) && !call_hit |=> dist_run ##1 s_run ##0 last_src == ABSEQ_SRC_KEY)
    else $error("key start");
  a_call_start: assert property (idle && call_hit |=> dist_run ##1 s_run ##0 last_src == ABSEQ_SRC_CALL)
    else $error("call start");
  a_local_blocked: assert property (idle && rx_valid && rx_local && !trip_in && !$rose(local_ident_key) |=> !dist_run)
    else $error("local call");
  a_trip_latched: assert property (idle && trip_used_q && !rx_valid && !local_ident_key |=> !dist_run)
    else $error("trip reuse");
  a_run_holds: assert property (dist_run && !dist_cycle_end |=> dist_run)
    else $error("early stop");
  a_stop_ends_run: assert property (s_end ##0 row_stop[nxt_row] |=> !dist_run && seq_done)
    else $error("stop row");
endmodule : abseq_monitor

bind abseq_core abseq_monitor #(.CALL_CHAR(CALL_CHAR), .ROWS(ROWS)) u_mon (.clk, .rst, .rx_valid,
  .rx_char, .rx_local, .local_ident_key, .trip_in, .row_code, .row_stop, .row_supp, .kbd_code,
  .dist_cycle_end, .dist_run, .dist_code, .line_mark, .seq_active, .cur_row, .last_src, .seq_done);

//--- verif/abseq_dist_model.sv
// Distributor and line model that sends one character per cycle while asked to run.
module abseq_dist_model
  import abseq_pkg::*;
#(
  parameter int CYC = 10
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sequencer side
  input wire logic dist_run,
  input wire logic [ABSEQ_LEVELS-1:0] dist_code,
  input wire logic line_mark,
  output logic dist_cycle_end,
  // Line side
  output logic ch_stb,
  output logic [8:0] ch_val
);
  int cnt_q;
  // The clutch stands still between messages, so each run starts a full cycle.
  always_ff @(posedge clk)
  begin
    if (rst || !dist_run)
    begin
      cnt_q <= 0;
      dist_cycle_end <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == CYC - 1) ? 0 : cnt_q + 1;
      dist_cycle_end <= (cnt_q == CYC - 2);
    end
  end
  always_ff @(posedge clk)
  begin
    ch_stb <= dist_cycle_end && !rst;
    ch_val <= line_mark ? 9'h1FF : {1'b0, dist_code};
  end
endmodule : abseq_dist_model

//--- verif/tb_top.sv
// Self-checking bench for the answerback sequencer.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import abseq_pkg::*;
  localparam logic [7:0] CALL = 8'h5A;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx_valid = 1'b0;
  logic [7:0] rx_char = 8'h00;
  logic rx_local = 1'b0;
  logic key = 1'b0;
  logic trip = 1'b0;
  logic [7:0] kbd = 8'h00;
  logic [ABSEQ_ROWS-1:0][ABSEQ_LEVELS-1:0] code;
  logic [ABSEQ_ROWS-1:0] stop;
  logic [ABSEQ_ROWS-1:0] supp;
  logic cyc_end, run, mark, active, done, stb;
  logic ign, first_err, nostop;
  logic [7:0] dcode, chars, cnt;
  logic [4:0] row;
  logic [1:0] src;
  logic [8:0] val;
  logic [8:0] got_q[$];
  int failures = 0;
  int n_compared = 0;
  always #2.5 clk = ~clk;
  abseq_core #(.CALL_CHAR(CALL)) dut (.clk(clk), .rst(rst), .rx_valid(rx_valid),
    .rx_char(rx_char), .rx_local(rx_local), .local_ident_key(key), .trip_in(trip),
    .row_code(code), .row_stop(stop), .row_supp(supp), .kbd_code(kbd),
    .dist_cycle_end(cyc_end), .dist_run(run), .dist_code(dcode), .line_mark(mark),
    .seq_active(active), .cur_row(row), .last_src(src), .seq_done(done), .trig_ignored(ign),
    .first_row_err(first_err), .no_stop_err(nostop), .chars_sent(chars), .seq_count(cnt));
  abseq_dist_model #(.CYC(10)) line (.clk(clk), .rst(rst), .dist_run(run), .dist_code(dcode),
    .line_mark(mark), .dist_cycle_end(cyc_end), .ch_stb(stb), .ch_val(val));
  always @(posedge clk)
    if (stb)
      got_q.push_back(val);
  task automatic conclude;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // The expected line is rebuilt from the store, from the given row up to the next stop.
  task automatic expect_msg(input int first);
    int r;
    int k;
    logic [8:0] exp_q[$];
    r = first;
    k = 0;
    do
    begin
      exp_q.push_back(supp[r] ? 9'h1FF : {1'b0, code[r]});
      r = (r == ABSEQ_ROWS - 1) ? 0 : r + 1;
    end
    while (!stop[r]);
    while (done !== 1'b1 && k < 2000)
    begin
      step(1);
      k++;
    end
    chk("done", 9'h001, {8'h00, done});
    step(3);
    chk("length", 9'(exp_q.size()), 9'(got_q.size()));
    foreach (exp_q[i]) chk("char", exp_q[i], got_q[i]);
    chk("row", 9'(r), {4'h0, row});
    got_q.delete();
  endtask : expect_msg
  task automatic t_idle;
    kbd = 8'h3C;
    step(2);
    chk("idle code", 9'h03C, {1'b0, dcode});
    chk("idle mark", 9'h000, {8'h00, mark});
    kbd = 8'h00;
    stop[0] = 1'b0;
    stop[5] = 1'b0;
    step(2);
    chk("no stop flag", 9'h001, {8'h00, nostop});
    stop[0] = 1'b1;
    stop[5] = 1'b1;
    step(2);
    chk("no stop flag", 9'h000, {8'h00, nostop});
  endtask : t_idle
  task automatic t_key;
    key = 1'b1;
    step(2);
    chk("key src", 9'(ABSEQ_SRC_KEY), {7'h00, src});
    expect_msg(0);
    key = 1'b0;
  endtask : t_key
  task automatic t_call;
    rx_char = CALL;
    rx_local = 1'b1;
    rx_valid = 1'b1;
    step(1);
    rx_valid = 1'b0;
    step(4);
    chk("local", 9'h000, {8'h00, active});
    rx_local = 1'b0;
    rx_valid = 1'b1;
    step(1);
    rx_valid = 1'b0;
    step(1);
    chk("call src", 9'(ABSEQ_SRC_CALL), {7'h00, src});
    step(20);
    key = 1'b1;
    step(1);
    chk("ignored", 9'h001, {8'h00, ign});
    step(1);
    key = 1'b0;
    expect_msg(5);
  endtask : t_call
  task automatic t_trip;
    supp[0] = 1'b0;
    trip = 1'b1;
    expect_msg(0);
    chk("trip src", 9'(ABSEQ_SRC_TRIP), {7'h00, src});
    chk("first row flag", 9'h001, {8'h00, first_err});
    supp[0] = 1'b1;
    step(30);
    chk("trip held", 9'h000, {8'h00, active});
    trip = 1'b0;
    step(2);
    trip = 1'b1;
    expect_msg(5);
    trip = 1'b0;
    chk("sent", 9'h00F, {1'b0, chars});
    chk("count", 9'h004, {1'b0, cnt});
    chk("first row flag", 9'h000, {8'h00, first_err});
  endtask : t_trip
  initial
  begin
    for (int i = 0; i < ABSEQ_ROWS; i++)
      code[i] = 8'h40 | 8'(i);
    code[1] = 8'h0D;
    code[2] = 8'h0A;
    code[4] = 8'h44;
    stop = '0;
    stop[0] = 1'b1;
    stop[5] = 1'b1;
    supp = '0;
    supp[0] = 1'b1;
    supp[5] = 1'b1;
    supp[3] = 1'b1;
    step(20);
    rst = 1'b0;
    step(2);
    t_idle();
    t_key();
    t_call();
    t_trip();
    conclude();
  end
  initial
  begin
    #50000;
    failures++;
    conclude();
  end
endmodule : tb_top
